// [include/swpce_pkg.sv]
// Package of constants and types for the single-wire PIO command engine
package swpce_pkg;

  // ****************************************
  // Timing, in microseconds and in clock cycles
  // ****************************************
  localparam int CLK_MHZ       = 10;
  localparam int RST_MIN_US    = 480;  // Shortest line-low that counts as bus reset
  localparam int PDH_US        = 30;   // Wait after reset release before presence
  localparam int PDL_US        = 120;  // Presence pulse length
  localparam int SAMPLE_US     = 30;   // Slave sample delay after a falling edge
  localparam int TX0_HOLD_US   = 45;   // Hold time of a transmitted zero
  localparam int RST_CYC_DFLT  = RST_MIN_US * CLK_MHZ;
  localparam int PDH_CYC       = PDH_US * CLK_MHZ;
  localparam int PDL_CYC       = PDL_US * CLK_MHZ;
  localparam int SAMPLE_CYC    = SAMPLE_US * CLK_MHZ;
  localparam int TX0_CYC       = TX0_HOLD_US * CLK_MHZ;
  localparam int CNT_W         = 13;

  // ****************************************
  // Command codes and fixed data
  // ****************************************
  localparam logic [7:0] CMD_READ_ID   = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID  = 8'h55;
  localparam logic [7:0] CMD_CH_WRITE  = 8'h5A;
  localparam logic [7:0] CMD_CS_WRITE  = 8'hCC;
  localparam logic [7:0] CMD_ACT_CLEAR = 8'hC3;
  localparam logic [7:0] CONFIRM_BYTE  = 8'hAA;
  // Identity: arbitrary value, family code in the low byte, check byte on top
  localparam logic [63:0] ID_DFLT      = 64'h5A00_1234_5678_9A29;

  // ****************************************
  // Conditional-search register page
  // ****************************************
  localparam logic [15:0] ADDR_SEL_MASK = 16'h008B;
  localparam logic [15:0] ADDR_POL_SEL  = 16'h008C;
  localparam logic [15:0] ADDR_CTL_STAT = 16'h008D;
  localparam logic [7:0]  CTL_STAT_RST  = 8'h08;
  localparam logic [7:0]  SEL_MASK_RST  = 8'h00;
  localparam logic [7:0]  POL_SEL_RST   = 8'h00;
  localparam logic [7:0]  LATCH_RST     = 8'hFF;
  localparam int          CTL_ROS_BIT   = 2;
  localparam int          CTL_PORL_BIT  = 3;

  // ****************************************
  // Avalon register map (byte addresses)
  // ****************************************
  localparam logic [3:0] AVS_CTRL      = 4'h0;
  localparam logic [3:0] AVS_STATUS    = 4'h4;
  localparam logic [3:0] AVS_CSREGS    = 4'h8;
  localparam int         CTRL_EN_BIT   = 0;
  localparam logic       CTRL_EN_RST   = 1'b1;

  // ****************************************
  // Presence phases and command states
  // ****************************************
  localparam logic [1:0] PR_NONE = 2'h0;
  localparam logic [1:0] PR_WAIT = 2'h1;
  localparam logic [1:0] PR_LOW  = 2'h2;

  typedef enum logic [11:0] {
    ST_IDLE     = 12'h001,
    ST_ROM      = 12'h002,
    ST_RD_ID    = 12'h004,
    ST_MATCH    = 12'h008,
    ST_CTRL     = 12'h010,
    ST_CAW_DATA = 12'h020,
    ST_CAW_INV  = 12'h040,
    ST_CAW_CONF = 12'h080,
    ST_CAW_SAMP = 12'h100,
    ST_CS_ADDR  = 12'h200,
    ST_CS_DATA  = 12'h400,
    ST_ACT_CONF = 12'h800
  } swpce_state_t;

endpackage

// [hdl/swpce_top.sv]
// Single-wire PIO command engine with Avalon-MM status and control access
// Function
// - Output latch changes via channel write or reset input
// - Channel write loops until bus reset
// - Output byte bit0 is channel zero, true form
// - Update only when complement byte matches exactly
// - Update on last complement bit, timed by value
// - Send confirmation byte AAh after update
// - Strobe from confirmation bit 0 to bit 1 sample
// - Sample pins on last confirmation bit, send
// - Reset input low forces outputs off, ones
// - Register write takes address then data
// - Store each byte, address then increments
// - Ignore bytes after top register written
// - Activity latch sets on any pin transition
// - Clear command clears all activity latches
// - After clear, every read returns AAh
// - Reset, presence, ROM, control, then data
// - Accept eight-bit ROM command after presence
// - Read identity sends family, serial, check
// - Match identity; mismatch idles until reset
// - Control bit picks reset input or strobe
// - All channels sampled in one instant
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module swpce_top #(
  parameter int          RST_CYC = swpce_pkg::RST_CYC_DFLT,
  parameter logic [63:0] ID_CODE = swpce_pkg::ID_DFLT
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_dq_in,
  output logic             o_dq_out,
  output logic             o_dq_oe,
  input  wire logic [7:0]  i_pio_in,
  output logic      [7:0]  o_pio_out,
  output logic      [7:0]  o_pio_oe,
  input  wire logic        i_mp_in,
  output logic             o_mp_out,
  output logic             o_mp_oe
);

  localparam int CW = swpce_pkg::CNT_W;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (RST_CYC >= (1 << CW) - 1 || RST_CYC <= swpce_pkg::PDL_CYC) begin : g_bad_rst
    $error("RST_CYC out of range for the line counters");
  end

  localparam logic [CW-1:0] C_RST    = CW'(RST_CYC - 1);
  localparam logic [CW-1:0] C_PDH    = CW'(swpce_pkg::PDH_CYC - 1);
  localparam logic [CW-1:0] C_PDL    = CW'(swpce_pkg::PDL_CYC - 1);
  localparam logic [CW-1:0] C_SAMPLE = CW'(swpce_pkg::SAMPLE_CYC - 1);
  localparam logic [CW-1:0] C_TX0    = CW'(swpce_pkg::TX0_CYC - 1);
  localparam logic [CW-1:0] C_MAX    = '1;

  typedef struct packed {
    swpce_pkg::swpce_state_t st;
    logic          en;
    logic          dq_prev;
    logic [CW-1:0] low_run;
    logic [CW-1:0] slot_cnt;
    logic          in_slot;
    logic          slot_drv;
    logic          rst_seen;
    logic [1:0]    pres;
    logic [CW-1:0] pres_cnt;
    logic [7:0]    sh;
    logic [5:0]    bitn;
    logic          match;
    logic [7:0]    data_a;
    logic          pend;
    logic [15:0]   addr;
    logic [7:0]    out_latch;
    logic [7:0]    act;
    logic [7:0]    pio_prev;
    logic [7:0]    sel_mask;
    logic [7:0]    pol_sel;
    logic [7:0]    ctl_stat;
    logic          strobe;
    logic          dq_oe;
    logic [7:0]    pio_oe;
    logic          mp_oe;
    logic          wait_q;
    logic [31:0]   rdata;
  } swpce_regs_t;

  swpce_regs_t q;
  swpce_regs_t n;

  // States in which the device drives read slots
  function automatic logic is_tx(input swpce_pkg::swpce_state_t s);
    is_tx = (s == swpce_pkg::ST_RD_ID) || (s == swpce_pkg::ST_CAW_CONF) ||
            (s == swpce_pkg::ST_CAW_SAMP) || (s == swpce_pkg::ST_ACT_CONF);
  endfunction

  // Byte k of the identity, lowest byte first
  function automatic logic [7:0] id_byte(input logic [2:0] k);
    id_byte = ID_CODE[{k, 3'b000} +: 8];
  endfunction

  logic       fall;
  logic       rise;
  logic       bit_ev;
  logic       rxbit;
  logic       last8;
  logic       act_clr;
  logic [7:0] newsh;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n       = q;
    fall    = q.dq_prev & ~i_dq_in;
    rise    = ~q.dq_prev & i_dq_in;
    rxbit   = i_dq_in;
    act_clr = 1'b0;
    last8   = (q.bitn[2:0] == 3'd7);
    newsh   = {is_tx(q.st) ? 1'b1 : rxbit, q.sh[7:1]};
    bit_ev  = q.in_slot && (q.slot_cnt == C_SAMPLE);
    n.dq_prev  = i_dq_in;
    n.pio_prev = i_pio_in;

    // Line-low run length, saturating, for reset detection
    n.low_run = i_dq_in ? '0 : ((q.low_run == C_MAX) ? q.low_run : q.low_run + 1'b1);

    // Slot timer restarts at every master falling edge
    if (fall) begin
      n.slot_cnt = '0;
    end else if (q.slot_cnt != C_MAX) begin
      n.slot_cnt = q.slot_cnt + 1'b1;
    end
    if (q.in_slot && q.slot_cnt == C_TX0) begin
      n.in_slot  = 1'b0;
      n.slot_drv = 1'b0;
    end
    if (fall && q.en && q.pres == swpce_pkg::PR_NONE && q.st != swpce_pkg::ST_IDLE) begin
      n.in_slot  = 1'b1;
      // Hold the line low for a transmitted zero
      n.slot_drv = is_tx(q.st) && !q.sh[0];
      if (q.st == swpce_pkg::ST_CAW_CONF && q.bitn == 6'd0 && q.ctl_stat[swpce_pkg::CTL_ROS_BIT]) begin
        n.strobe = 1'b1;
      end
    end

    // zero-bit update waits for line release
    if (q.pend && rise) begin
      n.out_latch = q.data_a;
      n.pend      = 1'b0;
    end

    // ****************************************
    // Bit and byte handling at the sample point
    // ****************************************
    if (bit_ev) begin
      n.sh   = newsh;
      n.bitn = q.bitn + 1'b1;
      unique case (q.st)
        swpce_pkg::ST_ROM: begin
          if (last8) begin
            n.bitn = '0;
            if (newsh == swpce_pkg::CMD_READ_ID) begin
              n.st = swpce_pkg::ST_RD_ID;
              n.sh = id_byte(3'd0);
            end else if (newsh == swpce_pkg::CMD_MATCH_ID) begin
              n.st    = swpce_pkg::ST_MATCH;
              n.match = 1'b1;
            end else begin
              n.st = swpce_pkg::ST_IDLE;
            end
          end
        end
        swpce_pkg::ST_RD_ID: begin
          if (last8) begin
            if (q.bitn == 6'd63) begin
              n.st = swpce_pkg::ST_IDLE;
            end else begin
              n.sh = id_byte(3'(q.bitn[5:3] + 3'd1));
            end
          end
        end
        swpce_pkg::ST_MATCH: begin
          if (rxbit != ID_CODE[q.bitn]) begin
            n.match = 1'b0;
          end
          if (q.bitn == 6'd63) begin
            n.bitn = '0;
            n.st   = (q.match && rxbit == ID_CODE[63]) ? swpce_pkg::ST_CTRL : swpce_pkg::ST_IDLE;
          end
        end
        // control command follows the ROM phase
        swpce_pkg::ST_CTRL: begin
          if (last8) begin
            n.bitn = '0;
            if (newsh == swpce_pkg::CMD_CH_WRITE) begin
              n.st = swpce_pkg::ST_CAW_DATA;
            end else if (newsh == swpce_pkg::CMD_CS_WRITE) begin
              n.st = swpce_pkg::ST_CS_ADDR;
            end else if (newsh == swpce_pkg::CMD_ACT_CLEAR) begin
              act_clr = 1'b1;
              n.st    = swpce_pkg::ST_ACT_CONF;
              n.sh    = swpce_pkg::CONFIRM_BYTE;
            end else begin
              n.st = swpce_pkg::ST_IDLE;
            end
          end
        end
        swpce_pkg::ST_CAW_DATA: begin
          if (last8) begin
            n.data_a = newsh;
            n.st     = swpce_pkg::ST_CAW_INV;
          end
        end
        swpce_pkg::ST_CAW_INV: begin
          if (last8) begin
            if (newsh == ~q.data_a) begin
              // channel write loads the latch here or on rise; reset input also sets it
              if (rxbit) begin
                n.out_latch = q.data_a;
              end else begin
                n.pend = 1'b1;
              end
              n.st = swpce_pkg::ST_CAW_CONF;
              // Confirmation bits count from zero, so the strobe finds bit 0
              n.bitn = '0;
              n.sh = swpce_pkg::CONFIRM_BYTE;
            end else begin
              n.st = swpce_pkg::ST_IDLE;
            end
          end
        end
        swpce_pkg::ST_CAW_CONF: begin
          if (q.bitn == 6'd1) begin
            n.strobe = 1'b0;
          end
          if (last8) begin
            n.sh = i_pio_in;
            n.st = swpce_pkg::ST_CAW_SAMP;
          end
        end
        // loop back for another output byte
        swpce_pkg::ST_CAW_SAMP: begin
          if (last8) begin
            n.st = swpce_pkg::ST_CAW_DATA;
          end
        end
        swpce_pkg::ST_CS_ADDR: begin
          n.addr = {rxbit, q.addr[15:1]};
          if (q.bitn == 6'd15) begin
            n.bitn = '0;
            n.st   = swpce_pkg::ST_CS_DATA;
          end
        end
        swpce_pkg::ST_CS_DATA: begin
          if (last8) begin
            // store at once, then next address
            n.addr = q.addr + 16'h0001;
            if (q.addr == swpce_pkg::ADDR_SEL_MASK) begin
              n.sel_mask = newsh;
            end else if (q.addr == swpce_pkg::ADDR_POL_SEL) begin
              n.pol_sel = newsh;
            end else if (q.addr == swpce_pkg::ADDR_CTL_STAT) begin
              // pin mode bit; power-on flag can only clear
              n.ctl_stat = {4'h0, newsh[3] & q.ctl_stat[swpce_pkg::CTL_PORL_BIT], newsh[2:0]};
            end
            if (q.addr < swpce_pkg::ADDR_SEL_MASK || q.addr >= swpce_pkg::ADDR_CTL_STAT) begin
              n.st = swpce_pkg::ST_IDLE;
            end
          end
        end
        swpce_pkg::ST_ACT_CONF: begin
          if (last8) begin
            n.sh = swpce_pkg::CONFIRM_BYTE;
          end
        end
        swpce_pkg::ST_IDLE: begin
          n.bitn = q.bitn;
        end
      endcase
    end

    // ****************************************
    // Bus reset and presence
    // ****************************************
    // long low resets command state
    if (!i_dq_in && q.low_run == C_RST) begin
      n.rst_seen = 1'b1;
      n.st       = swpce_pkg::ST_IDLE;
      n.in_slot  = 1'b0;
      n.slot_drv = 1'b0;
      n.strobe   = 1'b0;
      n.pres     = swpce_pkg::PR_NONE;
    end
    if (q.rst_seen && rise) begin
      n.rst_seen = 1'b0;
      n.pres     = q.en ? swpce_pkg::PR_WAIT : swpce_pkg::PR_NONE;
      n.pres_cnt = '0;
    end
    if (q.pres != swpce_pkg::PR_NONE) begin
      n.pres_cnt = q.pres_cnt + 1'b1;
      if (q.pres == swpce_pkg::PR_WAIT && q.pres_cnt == C_PDH) begin
        n.pres     = swpce_pkg::PR_LOW;
        n.pres_cnt = '0;
      end else if (q.pres == swpce_pkg::PR_LOW && q.pres_cnt == C_PDL) begin
        n.pres = swpce_pkg::PR_NONE;
        n.st   = swpce_pkg::ST_ROM;
        n.bitn = '0;
      end
    end

    // reset input low forces outputs off
    if (!q.ctl_stat[swpce_pkg::CTL_ROS_BIT] && !i_mp_in) begin
      n.out_latch = swpce_pkg::LATCH_RST;
      n.pend      = 1'b0;
    end
    // any pin change sets its latch; set wins over clear
    n.act = (act_clr ? 8'h00 : q.act) | (q.pio_prev ^ i_pio_in);

    // Pin drivers, open drain: a zero latch bit pulls the pin low
    n.dq_oe  = n.slot_drv || (n.pres == swpce_pkg::PR_LOW);
    n.pio_oe = ~n.out_latch;
    n.mp_oe  = n.strobe && n.ctl_stat[swpce_pkg::CTL_ROS_BIT];

    // ****************************************
    // Avalon slave: one wait cycle per access
    // ****************************************
    n.wait_q = 1'b1;
    if ((i_avs_read || i_avs_write) && q.wait_q) begin
      n.wait_q = 1'b0;
      unique case (i_avs_address)
        swpce_pkg::AVS_CTRL:   n.rdata = {31'h0000_0000, q.en};
        swpce_pkg::AVS_STATUS: n.rdata = {8'h00, i_pio_in, q.act, q.out_latch};
        swpce_pkg::AVS_CSREGS: n.rdata = {8'h00, q.ctl_stat, q.pol_sel, q.sel_mask};
        default:               n.rdata = 32'h0000_0000;
      endcase
    end
    // Write takes effect on the edge after the wait ends, with wait request low
    if (i_avs_write && !q.wait_q && i_avs_byteenable[0] && i_avs_address == swpce_pkg::AVS_CTRL) begin
      n.en = i_avs_writedata[swpce_pkg::CTRL_EN_BIT];
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q           <= '0;
      q.st        <= swpce_pkg::ST_IDLE;
      q.en        <= swpce_pkg::CTRL_EN_RST;
      q.dq_prev   <= 1'b1;
      // Pins idle high, so reset must not look like an activity edge
      q.pio_prev  <= swpce_pkg::LATCH_RST;
      q.out_latch <= swpce_pkg::LATCH_RST;
      q.sel_mask  <= swpce_pkg::SEL_MASK_RST;
      q.pol_sel   <= swpce_pkg::POL_SEL_RST;
      q.ctl_stat  <= swpce_pkg::CTL_STAT_RST;
      q.wait_q    <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register; data outputs tied low
  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = q.wait_q;
  assign o_dq_out          = 1'b0;
  assign o_dq_oe           = q.dq_oe;
  assign o_pio_out         = 8'h00;
  assign o_pio_oe          = q.pio_oe;
  assign o_mp_out          = 1'b0;
  assign o_mp_oe           = q.mp_oe;

endmodule

// [verification/swpce_checker_properties.sv]
// Port-level assertions for the single-wire command engine
`timescale 1ns/1ns
module swpce_checker #(
  parameter int RST_CYC = 4800
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rstn,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic       i_dq_in,
  input wire logic       o_dq_oe,
  input wire logic [7:0] o_pio_oe,
  input wire logic       o_mp_oe
);
  // ****************************************
  // Helper counters and clocking
  // ****************************************
  logic [12:0] low_q;   // Cycles the line has been low
  logic [12:0] pull_q;  // Cycles the device has pulled the line
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // Saturating counts, so a stuck line cannot wrap back into a legal range
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      low_q  <= 13'h0000;
      pull_q <= 13'h0000;
    end else begin
      low_q  <= i_dq_in ? 13'h0000 : low_q + {12'h000, ~&low_q};
      pull_q <= !o_dq_oe ? 13'h0000 : pull_q + {12'h000, ~&pull_q};
    end
  end

  // ****************************************
  // Line, latch and strobe timing
  // ****************************************
  a_pull_bound: assert property (pull_q <= 13'h04B0)
    else $error("Device pulled the line longer than a presence pulse");
  a_presence_due: assert property (i_dq_in && low_q >= RST_CYC |-> ##[280:320] o_dq_oe)
    else $error("No presence pulse after a bus reset");
  a_reset_quiet: assert property (low_q >= RST_CYC |-> !o_dq_oe)
    else $error("Device pulled the line during a bus reset");
  a_zero_slot: assert property ($rose(o_dq_oe) && !$past(i_dq_in) |-> o_dq_oe[*8] ##[1:500] !o_dq_oe)
    else $error("Transmitted zero has a wrong length");
  a_latch_on_high: assert property ($changed(o_pio_oe) |-> i_dq_in)
    else $error("Output latch changed while the line was low");
  a_strobe_start: assert property ($rose(o_mp_oe) |-> !$past(i_dq_in))
    else $error("Strobe began outside a slot");
  a_strobe_len: assert property ($rose(o_mp_oe) |-> o_mp_oe[*8] ##[1:1000] !o_mp_oe)
    else $error("Strobe length out of range");

  // Register bus answers one cycle after the request, for one cycle
  a_avs_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Register access not answered in one cycle");
  a_avs_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("Wait request low for more than one cycle");
endmodule

bind swpce_top swpce_checker #(.RST_CYC(RST_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_dq_in(i_dq_in), .o_dq_oe(o_dq_oe), .o_pio_oe(o_pio_oe),
  .o_mp_oe(o_mp_oe)
);

// [verification/swpce_master_model.sv]
// Behavioural single-wire bus master facing the command engine
`timescale 1ns/1ns
module swpce_master_model #(
  parameter int RST_CYC = 4800
) (
  input  wire logic i_clk_sys,
  input  wire logic i_line,
  output logic      o_drive_low
);
  // ****************************************
  // Slot tasks
  // ****************************************
  // Released line floats high through the pull-up
  initial begin
    o_drive_low = 1'h0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // reset pulse, presence sampled a quarter into the pulse, idle high after
  task automatic bus_reset(output logic pres);
    @(posedge i_clk_sys);
    o_drive_low <= 1'h1;
    wait_cyc(RST_CYC + 20);
    o_drive_low <= 1'h0;
    wait_cyc(600);
    pres = !i_line;
    wait_cyc(1000);
  endtask

  // a one is released early, a zero held past the sample point
  task automatic write_bit(input logic b);
    @(posedge i_clk_sys);
    o_drive_low <= 1'h1;
    wait_cyc(b ? 5 : 302);
    o_drive_low <= 1'h0;
    wait_cyc(b ? 300 : 3);
  endtask

  // Slot outlasts the longest zero the device may send
  task automatic read_bit(output logic b);
    @(posedge i_clk_sys);
    o_drive_low <= 1'h1;
    wait_cyc(3);
    o_drive_low <= 1'h0;
    wait_cyc(60);
    b = i_line;
    wait_cyc(400);
  endtask

  // bytes go least significant bit first
  task automatic write_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) write_bit(d[i]);
  endtask

  task automatic read_byte(output logic [7:0] d);
    logic b;
    for (int i = 0; i < 8; i++) begin
      read_bit(b);
      d[i] = b;
    end
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the single-wire command engine
`timescale 1ns/1ns
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int          RST_CYC = 1300;
  localparam logic [63:0] TB_ID   = 64'h2C00_1357_9BDF_0246;  // Arbitrary identity
  logic        i_clk_sys = 1'h0;
  logic        i_rstn    = 1'h0;
  logic [3:0]  avs_addr  = 4'h0;
  logic        avs_read  = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_wdata = 32'h0000_0000;
  logic [7:0]  ext_pio   = 8'hFF;
  logic [3:0]  avs_be    = 4'hF;
  wire  [31:0] avs_rdata;
  wire         avs_wait, drv_low, dq_oe, mp_oe, dq_line, mp_in, dq_out, mp_out;
  wire  [7:0]  pio_oe, pio_in, pio_out;
  int          cyc = 0, strobe_cnt = 0, miscompares = 0, num_checks = 0;

  // Open-drain wires: low if anyone pulls, else pulled up
  assign dq_line = ~(drv_low | dq_oe);
  assign pio_in  = ~pio_oe & ext_pio;
  assign mp_in   = ~mp_oe;

  swpce_top #(.RST_CYC(RST_CYC), .ID_CODE(TB_ID)) uut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_address(avs_addr), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_dq_in(dq_line), .o_dq_out(dq_out),
    .o_dq_oe(dq_oe), .i_pio_in(pio_in), .o_pio_out(pio_out), .o_pio_oe(pio_oe), .i_mp_in(mp_in),
    .o_mp_out(mp_out), .o_mp_oe(mp_oe)
  );
  swpce_master_model #(.RST_CYC(RST_CYC)) u_master (
    .i_clk_sys(i_clk_sys), .i_line(dq_line), .o_drive_low(drv_low)
  );

  // Clock, strobe counter and hang guard
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (mp_oe === 1'h1) strobe_cnt++;
    if (cyc == 200000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h, expected %h", $time, got, exp);
    end
  endtask

  // Request held until wait request is seen low at an edge
  task automatic avs_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd);
    avs_addr  <= addr;
    avs_wdata <= wd;
    avs_write <= wr;
    avs_read  <= ~wr;
    @(posedge i_clk_sys);
    while (avs_wait !== 1'h0) @(posedge i_clk_sys);
    rd = avs_rdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge i_clk_sys);
  endtask

  task automatic start_match;
    logic p;
    u_master.bus_reset(p);
    check({31'h0, p}, 32'h0000_0001);
    u_master.write_byte(swpce_pkg::CMD_MATCH_ID);
    for (int i = 0; i < 8; i++) u_master.write_byte(TB_ID[8*i +: 8]);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] rd;
    avs_xfer(1'h0, swpce_pkg::AVS_CTRL, 32'h0000_0000, rd);
    check({31'h0, rd[0]}, 32'h0000_0001);
    // A write without lane 0 must leave the link enabled
    avs_be <= 4'hE;
    avs_xfer(1'h1, swpce_pkg::AVS_CTRL, 32'h0000_0000, rd);
    avs_be <= 4'hF;
    avs_xfer(1'h0, swpce_pkg::AVS_CTRL, 32'h0000_0000, rd);
    check({31'h0, rd[0]}, 32'h0000_0001);
    avs_xfer(1'h0, swpce_pkg::AVS_STATUS, 32'h0000_0000, rd);
    check({16'h0000, rd[23:16], rd[7:0]}, 32'h0000_FFFF);
    avs_xfer(1'h0, swpce_pkg::AVS_CSREGS, 32'h0000_0000, rd);
    check({8'h00, rd[23:0]}, 32'h0008_0000);
    avs_xfer(1'h1, 4'hC, 32'hFFFF_FFFF, rd);
    avs_xfer(1'h0, 4'hC, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
  endtask

  task automatic t_read_id;
    logic       p;
    logic [7:0] b;
    u_master.bus_reset(p);
    check({31'h0, p}, 32'h0000_0001);
    u_master.write_byte(swpce_pkg::CMD_READ_ID);
    u_master.read_byte(b);
    check({24'h0, b}, {24'h0, TB_ID[7:0]});
    u_master.read_byte(b);
    check({24'h0, b}, {24'h0, TB_ID[15:8]});
  endtask

  // Start one below the top register so the stop at the top shows
  task automatic t_cs_write;
    logic [31:0] rd;
    start_match();
    u_master.write_byte(swpce_pkg::CMD_CS_WRITE);
    u_master.write_byte(8'h8C);
    u_master.write_byte(8'h00);
    u_master.write_byte(8'h81);
    u_master.write_byte(8'h0C);
    u_master.write_byte(8'h77);
    avs_xfer(1'h0, swpce_pkg::AVS_CSREGS, 32'h0000_0000, rd);
    check({8'h00, rd[23:0]}, 32'h000C_8100);
  endtask

  // Strobe mode is on here, so the strobe must appear with the confirmation
  task automatic t_chan_write;
    logic [31:0] rd;
    logic [7:0]  b;
    int          s0;
    start_match();
    u_master.write_byte(swpce_pkg::CMD_CH_WRITE);
    u_master.write_byte(8'h3C);
    u_master.write_byte(8'hC3);
    check({24'h0, pio_oe}, 32'h0000_00C3);
    s0 = strobe_cnt;
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_00AA);
    check({31'h0, strobe_cnt > s0}, 32'h0000_0001);
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_003C);
    // Second pass ends on a zero, so the update waits for the line rise
    u_master.write_byte(8'h96);
    u_master.write_byte(8'h69);
    check({24'h0, pio_oe}, 32'h0000_0069);
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_00AA);
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_0096);
    u_master.write_byte(8'hF0);
    u_master.write_byte(8'hF1);
    check({24'h0, pio_oe}, 32'h0000_0069);
    ext_pio <= 8'hFB;
    repeat (3) @(posedge i_clk_sys);
    avs_xfer(1'h0, swpce_pkg::AVS_STATUS, 32'h0000_0000, rd);
    check({8'h00, rd[23:0]}, 32'h0092_EF96);
    check({22'h0, dq_out, mp_out, pio_out}, 32'h0000_0000);
  endtask

  task automatic t_act_clear;
    logic [31:0] rd;
    logic [7:0]  b;
    start_match();
    u_master.write_byte(swpce_pkg::CMD_ACT_CLEAR);
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_00AA);
    u_master.read_byte(b);
    check({24'h0, b}, 32'h0000_00AA);
    avs_xfer(1'h0, swpce_pkg::AVS_STATUS, 32'h0000_0000, rd);
    check({24'h0, rd[15:8]}, 32'h0000_0000);
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'h1;
    @(posedge i_clk_sys);
    t_regs();
    t_read_id();
    t_cs_write();
    t_chan_write();
    t_act_clear();
    finish_test();
  end
endmodule
